// ### include/eeprom_rd_pkg.sv
package eeprom_rd_pkg;

	// ********************************
	// Array and pointer geometry
	// ********************************
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int MEM_WORDS = 8192;
	localparam int HI_USED_W = 5;
	localparam int FIFO_DEPTH = 32;
	localparam logic [ADDR_W-1:0] PTR_RST = 13'h0000;
	localparam logic [ADDR_W-1:0] PTR_STEP = 13'h0001;

	// ********************************
	// Control byte layout and bit counting
	// ********************************
	// Device-type code: value is arbitrary
	localparam logic [3:0] DEV_TYPE_CODE = 4'h5;
	localparam int CODE_MSB = 7;
	localparam int CODE_LSB = 4;
	localparam int CS_MSB = 3;
	localparam int CS_LSB = 1;
	localparam int RW_BIT = 0;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [3:0] CNT_ZERO = 4'h0;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_CTRL,
		ST_ACK_CTRL,
		ST_ADDR_HI,
		ST_ACK_HI,
		ST_ADDR_LO,
		ST_ACK_LO,
		ST_WDATA,
		ST_TX,
		ST_ACK_RX
	} state_e;

	typedef struct packed {
		logic scl;
		logic sda;
		logic [2:0] cs;
	} pins_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} load_word_s;

	localparam int LOAD_W = ADDR_W + DATA_W;

	typedef struct packed {
		pins_s sy1;
		pins_s sy2;
		pins_s sy3;
		state_e st;
		logic [3:0] cnt;
		logic [DATA_W-1:0] sh;
		logic [DATA_W-1:0] hi;
		logic [ADDR_W-1:0] ptr;
		logic rw;
		logic ack;
		logic oe;
		logic sda_out;
		logic busy;
	} core_s;

	localparam core_s CORE_RST = '0;

endpackage

// ### design/eeprom_rd_target.sv
// How it works
// RULE1 - Master loads the word address with a write-type control byte.
// RULE2 - Repeated start drops the write but keeps the loaded pointer.
// RULE3 - Master then resends the control byte with read direction.
// RULE4 - Matching read control byte is acked; pointer byte follows MSB first.
// RULE5 - Master nacks then stops; device then stops driving the data line.
// RULE6 - After a read the pointer holds the address after the byte sent.
// RULE7 - Each master ack makes the device send the next consecutive byte.
// RULE8 - Master ends a sequential read with no acknowledge and a stop.
// RULE9 - Pointer advances by one after every byte sent.
// RULE10 - Pointer wraps from the top address to zero; streaming goes on.
// RULE11 - Respond only to matching device-type code and chip select bits.
// RULE12 - Word address is two bytes, high first; only the low 13 bits count.
// RULE13 - On a master nack the device releases the data line high.
`timescale 1ns/10ps

// ********************************
// Loading queue
// ********************************
module word_fifo #(
	parameter int WIDTH = 21,
	parameter int DEPTH = 32
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_L = DEPTH[AW:0];

	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
		logic room;
	} fifo_st_s;

	fifo_st_s r, n;
	logic [WIDTH-1:0] buf_mem [0:DEPTH-1];
	logic push, pop;

	assign in_ready_o = r.room;
	assign out_valid_o = (r.wp != r.rp);
	assign out_data_o = buf_mem[r.rp[AW-1:0]];
	assign push = in_valid_i & r.room;
	assign pop = out_valid_o & out_ready_i;

	always_comb begin
		n = r;
		if (push) begin
			n.wp = r.wp + 1'b1;
		end
		if (pop) begin
			n.rp = r.rp + 1'b1;
		end
		n.room = ((n.wp - n.rp) != DEPTH_L);
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '{wp: '0, rp: '0, room: 1'b1};
		end else if (ce_i) begin
			r <= n;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (ce_i && push) begin
			buf_mem[r.wp[AW-1:0]] <= in_data_i;
		end
	end
endmodule

// ********************************
// Two-wire read target
// ********************************
module eeprom_rd_target (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic chip_select_bit_high_i,
	input wire logic chip_select_bit_mid_i,
	input wire logic chip_select_bit_low_i,
	input wire logic load_valid_i,
	input wire eeprom_rd_pkg::load_word_s load_word_i,
	output logic load_ready_o,
	output logic busy_o
);
	eeprom_rd_pkg::core_s r, n;
	logic [eeprom_rd_pkg::DATA_W-1:0] mem [0:eeprom_rd_pkg::MEM_WORDS-1];
	logic [eeprom_rd_pkg::DATA_W-1:0] mem_rd;
	logic [eeprom_rd_pkg::LOAD_W-1:0] q_data;
	eeprom_rd_pkg::load_word_s q_word;
	logic q_valid, q_ready, fifo_ready, mem_we;
	logic scl_rise, scl_fall, start_evt, stop_evt;
	logic rx_state, at_byte_end, ctrl_match;

	word_fifo #(
		.WIDTH(eeprom_rd_pkg::LOAD_W),
		.DEPTH(eeprom_rd_pkg::FIFO_DEPTH)
	) u_load_fifo (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.in_valid_i(load_valid_i),
		.in_data_i(load_word_i),
		.in_ready_o(fifo_ready),
		.out_valid_o(q_valid),
		.out_data_o(q_data),
		.out_ready_i(q_ready)
	);

	// Loads drain only between transactions so a read never sees a
	// half-updated array; a long bus session backs the queue up.
	assign q_word = q_data;
	assign q_ready = (r.st == eeprom_rd_pkg::ST_IDLE);
	assign mem_we = q_valid & q_ready;
	assign mem_rd = mem[r.ptr];

	always_ff @(posedge sys_clk_i) begin
		if (ce_i && mem_we) begin
			mem[q_word.addr] <= q_word.data;
		end
	end

	// Edges are taken from the second and third stages only
	assign scl_rise = r.sy2.scl & ~r.sy3.scl;
	assign scl_fall = ~r.sy2.scl & r.sy3.scl;
	assign start_evt = r.sy2.scl & r.sy3.scl & ~r.sy2.sda & r.sy3.sda;
	assign stop_evt = r.sy2.scl & r.sy3.scl & r.sy2.sda & ~r.sy3.sda;
	assign rx_state = (r.st == eeprom_rd_pkg::ST_CTRL) ||
		(r.st == eeprom_rd_pkg::ST_ADDR_HI) ||
		(r.st == eeprom_rd_pkg::ST_ADDR_LO) ||
		(r.st == eeprom_rd_pkg::ST_WDATA);
	assign at_byte_end = scl_fall && (r.cnt == eeprom_rd_pkg::BITS_PER_BYTE);
	assign ctrl_match = (r.sh[eeprom_rd_pkg::CODE_MSB:eeprom_rd_pkg::CODE_LSB]
		== eeprom_rd_pkg::DEV_TYPE_CODE) && // RULE11
		(r.sh[eeprom_rd_pkg::CS_MSB:eeprom_rd_pkg::CS_LSB] == r.sy2.cs);

	always_comb begin
		n = r;
		n.sy1 = {scl_i, sda_i, chip_select_bit_high_i, chip_select_bit_mid_i,
			chip_select_bit_low_i};
		n.sy2 = r.sy1;
		n.sy3 = r.sy2;
		n.sda_out = 1'b0;
		if (rx_state && scl_rise) begin
			n.sh = {r.sh[eeprom_rd_pkg::DATA_W-2:0], r.sy2.sda};
			n.cnt = r.cnt + eeprom_rd_pkg::CNT_ONE;
		end
		if (stop_evt) begin
			n.st = eeprom_rd_pkg::ST_IDLE; // RULE5
			n.oe = 1'b0;
		end else if (start_evt) begin
			// Repeated start keeps the pointer; nothing is stored
			n.st = eeprom_rd_pkg::ST_CTRL; // RULE2
			n.cnt = eeprom_rd_pkg::CNT_ZERO;
			n.oe = 1'b0;
		end else begin
			case (r.st)
				eeprom_rd_pkg::ST_CTRL: begin
					if (at_byte_end) begin
						if (ctrl_match) begin
							n.st = eeprom_rd_pkg::ST_ACK_CTRL; // RULE4
							n.oe = 1'b1;
							n.rw = r.sh[eeprom_rd_pkg::RW_BIT];
						end else begin
							n.st = eeprom_rd_pkg::ST_IDLE; // RULE11
						end
					end
				end
				eeprom_rd_pkg::ST_ACK_CTRL: begin
					if (scl_fall) begin
						n.cnt = eeprom_rd_pkg::CNT_ZERO;
						if (r.rw) begin
							n.st = eeprom_rd_pkg::ST_TX; // RULE4
							n.sh = mem_rd;
							n.oe = ~mem_rd[eeprom_rd_pkg::DATA_W-1];
							n.cnt = eeprom_rd_pkg::CNT_ONE;
						end else begin
							n.st = eeprom_rd_pkg::ST_ADDR_HI; // RULE1
							n.oe = 1'b0;
						end
					end
				end
				eeprom_rd_pkg::ST_ADDR_HI: begin
					if (at_byte_end) begin
						n.hi = r.sh; // RULE12
						n.st = eeprom_rd_pkg::ST_ACK_HI;
						n.oe = 1'b1;
					end
				end
				eeprom_rd_pkg::ST_ACK_HI: begin
					if (scl_fall) begin
						n.st = eeprom_rd_pkg::ST_ADDR_LO;
						n.cnt = eeprom_rd_pkg::CNT_ZERO;
						n.oe = 1'b0;
					end
				end
				eeprom_rd_pkg::ST_ADDR_LO: begin
					if (at_byte_end) begin
						n.ptr = {r.hi[eeprom_rd_pkg::HI_USED_W-1:0],
							r.sh}; // RULE12
						n.st = eeprom_rd_pkg::ST_ACK_LO;
						n.oe = 1'b1;
					end
				end
				eeprom_rd_pkg::ST_ACK_LO: begin
					if (scl_fall) begin
						n.st = eeprom_rd_pkg::ST_WDATA;
						n.cnt = eeprom_rd_pkg::CNT_ZERO;
						n.oe = 1'b0;
					end
				end
				eeprom_rd_pkg::ST_WDATA: begin
					// Write data is outside this block: no ack, no store
					if (at_byte_end) begin
						n.st = eeprom_rd_pkg::ST_IDLE;
					end
				end
				eeprom_rd_pkg::ST_TX: begin
					if (scl_fall) begin
						if (r.cnt == eeprom_rd_pkg::BITS_PER_BYTE) begin
							n.st = eeprom_rd_pkg::ST_ACK_RX;
							n.oe = 1'b0;
							n.ptr = r.ptr + // RULE9 RULE10
								eeprom_rd_pkg::PTR_STEP; // RULE6
						end else begin
							n.sh = {r.sh[eeprom_rd_pkg::DATA_W-2:0], 1'b0};
							n.oe = ~r.sh[eeprom_rd_pkg::DATA_W-2];
							n.cnt = r.cnt + eeprom_rd_pkg::CNT_ONE;
						end
					end
				end
				eeprom_rd_pkg::ST_ACK_RX: begin
					if (scl_rise) begin
						n.ack = ~r.sy2.sda;
					end
					if (scl_fall) begin
						if (r.ack) begin
							n.st = eeprom_rd_pkg::ST_TX; // RULE7
							n.sh = mem_rd;
							n.oe = ~mem_rd[eeprom_rd_pkg::DATA_W-1];
							n.cnt = eeprom_rd_pkg::CNT_ONE;
						end else begin
							n.st = eeprom_rd_pkg::ST_IDLE; // RULE13
							n.oe = 1'b0;
						end
					end
				end
				default: begin
					n.oe = 1'b0;
				end
			endcase
		end
		n.busy = (n.st != eeprom_rd_pkg::ST_IDLE);
	end
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			r <= eeprom_rd_pkg::CORE_RST;
		end else if (ce_i) begin
			r <= n;
		end
	end
	// Open drain: the pad only ever pulls low
	assign sda_o = r.sda_out;
	assign sda_oe_o = r.oe;
	assign busy_o = r.busy;
	assign load_ready_o = fifo_ready;

	// ********************************
	// Checks
	// ********************************
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	chk_ctrl_ack_drive: assert property ( // RULE4
		(r.st == eeprom_rd_pkg::ST_ACK_CTRL) |-> r.oe)
		else $error("control byte not acknowledged");
	chk_tx_msb_first: assert property ( // RULE4
		(r.st == eeprom_rd_pkg::ST_TX) |-> (r.oe == ~r.sh[7]))
		else $error("transmitted bit is not the shift msb");
	chk_ptr_advance: assert property ( // RULE9
		ce_i && (r.st == eeprom_rd_pkg::ST_TX) &&
		(n.st == eeprom_rd_pkg::ST_ACK_RX) |=>
		(r.ptr == $past(r.ptr) + 13'h0001))
		else $error("pointer did not advance after byte");
	chk_ptr_wrap: assert property ( // RULE10
		ce_i && (r.st == eeprom_rd_pkg::ST_TX) && (r.ptr == 13'h1FFF) &&
		(n.st == eeprom_rd_pkg::ST_ACK_RX) |=> (r.ptr == 13'h0000))
		else $error("pointer did not wrap to zero");
	chk_restart_keeps_ptr: assert property ( // RULE2
		ce_i && start_evt && !stop_evt |=> $stable(r.ptr) && !r.oe)
		else $error("repeated start disturbed the pointer");
	chk_stop_release: assert property ( // RULE5
		ce_i && stop_evt |=> !r.oe && (r.st == eeprom_rd_pkg::ST_IDLE))
		else $error("data line still driven after stop");
	chk_nack_release: assert property ( // RULE13
		(r.st == eeprom_rd_pkg::ST_ACK_RX) |-> !r.oe && !r.sda_out)
		else $error("data line driven during master ack slot");
	chk_addr_load: assert property ( // RULE12
		$rose(r.st == eeprom_rd_pkg::ST_ACK_LO) |->
		(r.ptr == {$past(r.hi[4:0]), $past(r.sh)}))
		else $error("word address loaded wrongly");
	chk_foreign_ignored: assert property ( // RULE11
		ce_i && (r.st == eeprom_rd_pkg::ST_CTRL) && at_byte_end &&
		!ctrl_match && !start_evt && !stop_evt |=> !r.oe [*2])
		else $error("foreign control byte acknowledged");
	chk_seq_next_byte: assert property ( // RULE7
		ce_i && (r.st == eeprom_rd_pkg::ST_ACK_RX) && scl_fall && r.ack &&
		!start_evt && !stop_evt |=>
		(r.st == eeprom_rd_pkg::ST_TX) && (r.sh == $past(mem_rd)))
		else $error("next byte not loaded after master ack");
	chk_no_load_in_xfer: assert property ( // RULE2
		mem_we |-> (r.st == eeprom_rd_pkg::ST_IDLE))
		else $error("array written during a transaction");
	cov_random_read: cover property (
		(r.st == eeprom_rd_pkg::ST_ACK_LO) ##[1:1000]
		(r.st == eeprom_rd_pkg::ST_ACK_CTRL) && r.rw);
	cov_seq_read: cover property (
		(r.st == eeprom_rd_pkg::ST_ACK_RX) && scl_fall && r.ack);
	cov_wrap: cover property (
		(r.ptr == 13'h1FFF) && (r.st == eeprom_rd_pkg::ST_TX));
	cov_queue_full: cover property (!fifo_ready);
endmodule

// ### sim/i2c_master_model.sv
`timescale 1ns/10ps
// ********************************
// Two-wire bus master, 160 ns bus clock
// ********************************
module i2c_master_model (
	input wire logic sys_clk_i,
	input wire logic sda_oe_i,
	input wire logic sda_dev_i,
	output logic scl_o,
	output logic sda_o
);
	logic drv_r;
	// Open drain with pull-up: pad value counts only while enabled
	assign sda_o = drv_r & (sda_oe_i ? sda_dev_i : 1'b1);
	initial begin
		scl_o = 1'b1;
		drv_r = 1'b1;
	end
	task automatic half();
		repeat (8) @(posedge sys_clk_i);
	endtask
	// Serves as repeated start too; clock stands high between frames
	task automatic start();
		drv_r <= 1'b1;
		half();
		scl_o <= 1'b1;
		half();
		drv_r <= 1'b0;
		half();
		scl_o <= 1'b0;
	endtask
	task automatic stop();
		drv_r <= 1'b0;
		half();
		scl_o <= 1'b1;
		half();
		drv_r <= 1'b1;
		half();
	endtask
	// Eight bits MSB first, then the ninth bit; ack_i high = no ack
	task automatic xfer(input logic [7:0] b, input logic ack_i,
		output logic [7:0] r, output logic ack_o);
		logic [8:0] v;
		logic [8:0] s;
		v = {b, ack_i};
		s = '0;
		repeat (9) begin
			drv_r <= v[8];
			half();
			scl_o <= 1'b1;
			half();
			s = {s[7:0], sda_o};
			v = v << 1;
			scl_o <= 1'b0;
		end
		r = s[8:1];
		ack_o = s[0];
	endtask
endmodule

// ### sim/serial_eeprom_random_seq_read_tb.sv
`timescale 1ns/10ps
module serial_eeprom_random_seq_read_tb;
	localparam logic [6:0] SEL = {eeprom_rd_pkg::DEV_TYPE_CODE, 3'h5};
	logic sys_clk_i, rst_i, load_valid_i, scl, sda, sda_oe_o;
	logic load_ready_o, busy_o, ak;
	logic sda_dev;
	logic [2:0] straps;
	eeprom_rd_pkg::load_word_s load_word_i;
	logic [7:0] r;
	int n_errors = 0;
	int cmp_count = 0;

	eeprom_rd_target DUT (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.ce_i(1'b1),
		.scl_i(scl),
		.sda_i(sda),
		.sda_o(sda_dev),
		.sda_oe_o(sda_oe_o),
		.chip_select_bit_high_i(straps[2]),
		.chip_select_bit_mid_i(straps[1]),
		.chip_select_bit_low_i(straps[0]),
		.load_valid_i(load_valid_i),
		.load_word_i(load_word_i),
		.load_ready_o(load_ready_o),
		.busy_o(busy_o)
	);
	i2c_master_model mst (
		.sys_clk_i(sys_clk_i),
		.sda_oe_i(sda_oe_o),
		.sda_dev_i(sda_dev),
		.scl_o(scl),
		.sda_o(sda)
	);

	// ********************************
	// Helpers
	// ********************************
	// Array holds index ^ 5A for the 32 words loaded from 1FF0 upward
	function automatic logic [7:0] exp_data(input logic [12:0] a);
		logic [12:0] k;
		k = a - 13'h1FF0;
		return k[7:0] ^ 8'h5A;
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic send(input logic [7:0] b);
		mst.xfer(b, 1'b1, r, ak);
		check({7'h0, ak}, 8'h00);
	endtask

	// ********************************
	// Scenarios
	// ********************************
	// An open frame keeps the queue from draining, so it must fill
	task automatic fill_fifo();
		int taken;
		taken = 0;
		mst.start();
		repeat (36) begin
			load_valid_i <= 1'b1;
			load_word_i <= {13'h1FF0 + 13'(taken), 8'(taken) ^ 8'h5A};
			@(negedge sys_clk_i);
			if (load_ready_o === 1'b1) taken++;
			@(posedge sys_clk_i);
		end
		check(8'(taken), 8'h20);
		check({7'h0, load_ready_o}, 8'h00);
		load_valid_i <= 1'b0;
		mst.stop();
		repeat (40) @(posedge sys_clk_i);
	endtask
	task automatic set_ptr(input logic [15:0] a);
		mst.start();
		send({SEL, 1'b0});
		send(a[15:8]);
		send(a[7:0]);
		mst.start();
		send({SEL, 1'b1});
	endtask
	task automatic rd_bytes(input logic [12:0] a, input int n);
		for (int k = 0; k < n; k++) begin
			mst.xfer(8'hFF, k == n - 1, r, ak);
			check(r, exp_data(a + 13'(k)));
		end
		check({7'h0, ak}, 8'h01);
		mst.stop();
		repeat (8) @(posedge sys_clk_i);
		check({7'h0, busy_o}, 8'h00);
		check({7'h0, sda_oe_o}, 8'h00);
	endtask
	task automatic refuse(input logic [7:0] b);
		mst.start();
		mst.xfer(b, 1'b1, r, ak);
		check({7'h0, ak}, 8'h01);
		mst.stop();
		repeat (8) @(posedge sys_clk_i);
		check({7'h0, busy_o}, 8'h00);
	endtask
	// Moved straps: the old select is refused, the new one answers
	task automatic move_straps();
		straps <= 3'h4;
		repeat (8) @(posedge sys_clk_i);
		refuse({eeprom_rd_pkg::DEV_TYPE_CODE, 3'h5, 1'b1});
		mst.start();
		send({eeprom_rd_pkg::DEV_TYPE_CODE, 3'h4, 1'b1});
		rd_bytes(13'h0002, 1);
	endtask

	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		#200000;
		n_errors++;
		complete_run();
	end
	initial begin
		rst_i = 1'b1;
		load_valid_i = 1'b0;
		load_word_i = '0;
		straps = 3'h5;
		repeat (16) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		fill_fifo();
		// Top three address bits set: they must be ignored
		set_ptr(16'hFFFE);
		rd_bytes(13'h1FFE, 1);
		mst.start();
		send({SEL, 1'b1});
		rd_bytes(13'h1FFF, 1);
		set_ptr(16'h1FFD);
		rd_bytes(13'h1FFD, 5);
		refuse({eeprom_rd_pkg::DEV_TYPE_CODE ^ 4'h1, 3'h5, 1'b1});
		refuse({eeprom_rd_pkg::DEV_TYPE_CODE, 3'h4, 1'b1});
		move_straps();
		complete_run();
	end
endmodule
